// ---- hw/cod_out_stage.sv ----
// Control decode for one sysref output stage.
module cod_out_stage
	import cod_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Stored settings.
	input wire logic pd,
	input wire logic fmt,
	input wire logic en,
	input wire logic [1:0] amp,
	// Stage controls.
	output logic powered,
	output logic lvpecl,
	output logic toggle,
	output logic static_low,
	output logic [9:0] amp_mv
);
	cod_stage_t q, d;

	always_comb begin
		d = '0;
		// A powered-down stage ignores format, enable and swing.
		if (!pd) begin
			d.powered = 1'b1;
			d.lvpecl = fmt;
			d.toggle = en;
			d.static_low = !en;
			d.amp_mv = cod_amp_mv(amp);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign powered = q.powered;
	assign lvpecl = q.lvpecl;
	assign toggle = q.toggle;
	assign static_low = q.static_low;
	assign amp_mv = q.amp_mv;

	pd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		pd |=> !powered && !toggle && !lvpecl && amp_mv == 10'h000)
		else $error("powered-down stage still active");
	// The sampled reset copy keeps an attempt from starting on the release
	// edge, while the stage flops still hold their reset value.
	amp_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !pd && amp == 2'h3 |=> amp_mv == 10'h3E8)
		else $error("swing code three not mapped to 1000 mV");
	amp_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !pd && amp == 2'h0 |=> amp_mv == 10'h0FA)
		else $error("swing code zero not mapped to 250 mV");
	fmt_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !pd |=> lvpecl == $past(fmt))
		else $error("format does not follow its bit");
	en_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !pd && !en |=> static_low && !toggle && powered)
		else $error("disabled output not held low");
endmodule // cod_out_stage

// ---- hw/cod_pkg.sv ----
// Constants, state types and helpers of the clock output and divider bank.
package cod_pkg;
	localparam int NUM_OUT = 8;
	// Register offsets.
	localparam logic [7:0] OFS_FB_WIN_HI = 8'h00;
	localparam logic [7:0] OFS_VCXO_FB_LO = 8'h01;
	localparam logic [7:0] OFS_SECOND_FB_LO = 8'h02;
	localparam logic [7:0] OFS_SECOND_FB_HI = 8'h03;
	localparam logic [7:0] OFS_REF_WIN_HI = 8'h04;
	localparam logic [7:0] OFS_REF_LO = 8'h05;
	localparam logic [7:0] OFS_SYNTH_FB_HI = 8'h08;
	localparam logic [7:0] OFS_SYNTH_FB_LO = 8'h09;
	localparam logic [7:0] OFS_PREDIV = 8'h0C;
	localparam logic [7:0] OFS_OSC_SEL = 8'h1F;
	localparam logic [7:0] OFS_SYSREF_EN = 8'h76;
	// Index 0 is the first sysref output, index 7 the last.
	localparam logic [7:0][7:0] OFS_SYSREF = {8'h5C, 8'h4D, 8'h4C, 8'h3D,
		8'h3C, 8'h2E, 8'h2D, 8'h2C};
	// Field positions inside the sysref output state registers.
	localparam int POS_PD = 7;
	localparam int POS_FMT = 4;
	localparam int POS_AMP = 2;
	// Reset values.
	localparam logic [11:0] RST_VCXO_FB = 12'hC00;
	localparam logic [8:0] RST_SECOND_FB = 9'h060;
	localparam logic [11:0] RST_REF_DIV = 12'h000;
	localparam logic [8:0] RST_SYNTH_FB = 9'h000;
	localparam logic [5:0] RST_PREDIV = 6'h00;
	// Amplitude codes in millivolts.
	localparam logic [9:0] AMP_MV_0 = 10'h0FA;
	localparam logic [9:0] AMP_MV_1 = 10'h1F4;
	localparam logic [9:0] AMP_MV_2 = 10'h2EE;
	localparam logic [9:0] AMP_MV_3 = 10'h3E8;

	typedef struct packed {
		logic [2:0] fb_ph;
		logic fb2_pd;
		logic [11:0] vcxo_fb;
		logic [8:0] fb2;
		logic bypass;
		logic [2:0] ref_ph;
		logic [11:0] ref_div;
		logic [8:0] synth_fb;
		logic div_flag;
		logic [5:0] prediv;
		logic osc_sel;
		logic [7:0] pd;
		logic [7:0] fmt;
		logic [7:0][1:0] amp;
		logic [7:0] en;
		logic [7:0] rdata;
		logic rvalid;
	} cod_regs_t;

	typedef struct packed {
		logic powered;
		logic lvpecl;
		logic toggle;
		logic static_low;
		logic [9:0] amp_mv;
	} cod_stage_t;

	// Same decode for both formats.
	function automatic logic [9:0] cod_amp_mv(input logic [1:0] code);
		logic [9:0] mv;
		mv = AMP_MV_0;
		case (code)
			2'h1: mv = AMP_MV_1;
			2'h2: mv = AMP_MV_2;
			2'h3: mv = AMP_MV_3;
			default: mv = AMP_MV_0;
		endcase
		return mv;
	endfunction
endpackage

// ---- hw/cod_regs.sv ----
// Clock output state and PLL divider configuration register bank.
module cod_regs
	import cod_pkg::*;
(
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RSTN,
	// Register port.
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WE,
	input wire logic REG_RE,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// Divider controls.
	output logic [2:0] FB_LOCK_WINDOW_PHASE,
	output logic SECOND_FB_POWER_DOWN,
	output logic SECOND_FB_ENABLE,
	output logic [11:0] VCXO_FEEDBACK_DIVIDER,
	output logic [8:0] SECOND_FEEDBACK_DIVIDER,
	output logic BYPASS_CONTROL,
	output logic [2:0] REF_LOCK_WINDOW_PHASE,
	output logic [11:0] REFERENCE_DIVIDER,
	output logic [8:0] SYNTH_FEEDBACK_DIVIDER,
	output logic DIVIDER_CONTROL_FLAG,
	output logic [5:0] SYNTH_PRE_DIVIDER,
	output logic OSCILLATOR_SELECT_BIT,
	// Sysref output stage controls.
	output logic [7:0] SYSREF_POWERED,
	output logic [7:0] SYSREF_LVPECL,
	output logic [7:0] SYSREF_TOGGLE,
	output logic [7:0] SYSREF_STATIC_LOW,
	output logic [7:0][9:0] SYSREF_AMP_MV
);
	logic [1:0] rsync_q;
	logic rst_n;
	cod_regs_t q, d;
	logic [7:0] rd;

	// Release is synchronised so every flop on rst_n leaves reset on the same edge.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rsync_q <= 2'b00;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_n = rsync_q[1];

	always_comb begin
		d = q;
		d.rvalid = 1'b0;
		rd = 8'h00;
		if (REG_WE) begin
			case (REG_ADDR)
				OFS_FB_WIN_HI: begin
					d.fb_ph = REG_WDATA[7:5];
					d.fb2_pd = REG_WDATA[4];
					d.vcxo_fb[11:8] = REG_WDATA[3:0];
				end
				OFS_VCXO_FB_LO: d.vcxo_fb[7:0] = REG_WDATA;
				OFS_SECOND_FB_LO: d.fb2[7:0] = REG_WDATA;
				OFS_SECOND_FB_HI: begin
					d.fb2[8] = REG_WDATA[7];
					d.bypass = REG_WDATA[0];
				end
				OFS_REF_WIN_HI: begin
					d.ref_ph = REG_WDATA[7:5];
					d.ref_div[11:8] = REG_WDATA[3:0];
				end
				OFS_REF_LO: d.ref_div[7:0] = REG_WDATA;
				OFS_SYNTH_FB_HI: d.synth_fb[8] = REG_WDATA[0];
				OFS_SYNTH_FB_LO: d.synth_fb[7:0] = REG_WDATA;
				OFS_PREDIV: begin
					d.div_flag = REG_WDATA[7];
					d.prediv = REG_WDATA[5:0];
				end
				OFS_OSC_SEL: d.osc_sel = REG_WDATA[0];
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_OUT; i++) begin
				if (REG_ADDR == OFS_SYSREF[i]) begin
					d.pd[i] = REG_WDATA[POS_PD];
					d.fmt[i] = REG_WDATA[POS_FMT];
					d.amp[i] = REG_WDATA[POS_AMP +: 2];
				end
				if (REG_ADDR == OFS_SYSREF_EN) begin
					d.en[i] = REG_WDATA[NUM_OUT - 1 - i];
				end
			end
		end
		// Reserved bits and unmapped offsets read as zero.
		case (REG_ADDR)
			OFS_FB_WIN_HI: rd = {q.fb_ph, q.fb2_pd, q.vcxo_fb[11:8]};
			OFS_VCXO_FB_LO: rd = q.vcxo_fb[7:0];
			OFS_SECOND_FB_LO: rd = q.fb2[7:0];
			OFS_SECOND_FB_HI: rd = {q.fb2[8], 6'h00, q.bypass};
			OFS_REF_WIN_HI: rd = {q.ref_ph, 1'b0, q.ref_div[11:8]};
			OFS_REF_LO: rd = q.ref_div[7:0];
			OFS_SYNTH_FB_HI: rd = {7'h00, q.synth_fb[8]};
			OFS_SYNTH_FB_LO: rd = q.synth_fb[7:0];
			OFS_PREDIV: rd = {q.div_flag, 1'b0, q.prediv};
			OFS_OSC_SEL: rd = {7'h00, q.osc_sel};
			default: begin
			end
		endcase
		for (int i = 0; i < NUM_OUT; i++) begin
			if (REG_ADDR == OFS_SYSREF[i]) begin
				rd[POS_PD] = q.pd[i];
				rd[POS_FMT] = q.fmt[i];
				rd[POS_AMP +: 2] = q.amp[i];
			end
			if (REG_ADDR == OFS_SYSREF_EN) begin
				rd[NUM_OUT - 1 - i] = q.en[i];
			end
		end
		if (REG_RE) begin
			d.rvalid = 1'b1;
			d.rdata = rd;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.vcxo_fb <= RST_VCXO_FB;
			q.fb2 <= RST_SECOND_FB;
			q.ref_div <= RST_REF_DIV;
			q.synth_fb <= RST_SYNTH_FB;
			q.prediv <= RST_PREDIV;
		end else begin
			q <= d;
		end
	end

	assign REG_RDATA = q.rdata;
	assign REG_RVALID = q.rvalid;
	assign FB_LOCK_WINDOW_PHASE = q.fb_ph;
	assign SECOND_FB_POWER_DOWN = q.fb2_pd;
	assign SECOND_FB_ENABLE = !q.fb2_pd;
	assign VCXO_FEEDBACK_DIVIDER = q.vcxo_fb;
	assign SECOND_FEEDBACK_DIVIDER = q.fb2;
	assign BYPASS_CONTROL = q.bypass;
	assign REF_LOCK_WINDOW_PHASE = q.ref_ph;
	assign REFERENCE_DIVIDER = q.ref_div;
	assign SYNTH_FEEDBACK_DIVIDER = q.synth_fb;
	assign DIVIDER_CONTROL_FLAG = q.div_flag;
	assign SYNTH_PRE_DIVIDER = q.prediv;
	assign OSCILLATOR_SELECT_BIT = q.osc_sel;

	// Stage controls are registered once more, so they lag a write by two edges.
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_stage
		cod_out_stage u_stage (
			.clk(CLOCK),
			.rst_n(rst_n),
			.pd(q.pd[g]),
			.fmt(q.fmt[g]),
			.en(q.en[g]),
			.amp(q.amp[g]),
			.powered(SYSREF_POWERED[g]),
			.lvpecl(SYSREF_LVPECL[g]),
			.toggle(SYSREF_TOGGLE[g]),
			.static_low(SYSREF_STATIC_LOW[g]),
			.amp_mv(SYSREF_AMP_MV[g])
		);
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!rst_n);

	sequence wr_s(logic [7:0] a);
		REG_WE && REG_ADDR == a;
	endsequence
	sequence rd_s(logic [7:0] a);
		REG_RE && !REG_WE && REG_ADDR == a;
	endsequence

	wr_reg00_a: assert property (wr_s(8'h00) |=>
		{FB_LOCK_WINDOW_PHASE, SECOND_FB_POWER_DOWN,
		VCXO_FEEDBACK_DIVIDER[11:8]} == $past(REG_WDATA))
		else $error("offset vcxo_fb_window_and_high fields misplaced");
	wr_reg03_a: assert property (wr_s(8'h03) |=>
		SECOND_FEEDBACK_DIVIDER[8] == $past(REG_WDATA[7]) &&
		BYPASS_CONTROL == $past(REG_WDATA[0]))
		else $error("offset second_fb_high_and_bypass fields misplaced");
	rsv_reg03_a: assert property (rd_s(8'h03) |=>
		REG_RVALID && REG_RDATA[6:1] == 6'h00)
		else $error("offset second_fb_high_and_bypass reserved bits not zero");
	// The host leaves one idle cycle between a write and the next read.
	wr_reg04_a: assert property (wr_s(8'h04) ##1 !REG_WE ##1
		rd_s(8'h04) |=>
		REG_RDATA == ($past(REG_WDATA, 3) & 8'hEF))
		else $error("offset ref_div_window_and_high readback wrong");
	wr_reg05_a: assert property (wr_s(8'h05) |=>
		REFERENCE_DIVIDER[7:0] == $past(REG_WDATA))
		else $error("reference divider low byte wrong");
	wr_reg08_a: assert property (wr_s(8'h08) ##1 !REG_WE ##1
		rd_s(8'h08) |=>
		REG_RDATA == {7'h00, SYNTH_FEEDBACK_DIVIDER[8]} &&
		SYNTH_FEEDBACK_DIVIDER[8] == $past(REG_WDATA[0], 3))
		else $error("synth feedback top bit misplaced");
	wr_reg0c_a: assert property (wr_s(8'h0C) |=>
		{DIVIDER_CONTROL_FLAG, SYNTH_PRE_DIVIDER} ==
		{$past(REG_WDATA[7]), $past(REG_WDATA[5:0])})
		else $error("offset synth_prediv_control fields misplaced");
	wr_reg1f_a: assert property (wr_s(8'h1F) |=>
		OSCILLATOR_SELECT_BIT == $past(REG_WDATA[0]))
		else $error("oscillator select misplaced");
	fb2_off_a: assert property (wr_s(8'h00) and REG_WDATA[4] |=>
		!SECOND_FB_ENABLE && SECOND_FB_POWER_DOWN)
		else $error("second divider not disabled");
	sysref_pd_a: assert property (wr_s(8'h2C) and REG_WDATA[7] |=>
		##1 !SYSREF_POWERED[0])
		else $error("first sysref output not powered down");
endmodule // cod_regs

// ---- verif/cod_host.sv ----
// Host model that drives the register port of the bank.
module cod_host (
	// Clock.
	input wire logic CLOCK,
	// Register port.
	output logic [7:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WE,
	output logic REG_RE,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		REG_WE = 1'b0;
		REG_RE = 1'b0;
	end

	// Released lines show the inverse, so a stale value never passes.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WE <= 1'b1;
		@(posedge CLOCK);
		REG_WE <= 1'b0;
		REG_ADDR <= ~a;
		REG_WDATA <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_RE <= 1'b1;
		@(posedge CLOCK);
		REG_RE <= 1'b0;
		REG_ADDR <= ~a;
		@(negedge CLOCK);
		v = REG_RVALID;
		d = REG_RDATA;
	endtask
endmodule // cod_host

// ---- verif/test_cod_regs.sv ----
// Self-checking bench of the clock output and divider bank.
module test_cod_regs import cod_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst_n, we, re, rvalid, fb2_pd, fb2_en, byp, flag, osc;
	logic [7:0] addr, wdata, rdata, s_pw, s_pecl, s_tog, s_low, en_v, sv;
	logic [2:0] fb_ph, ref_ph;
	logic [11:0] vcxo, ref_div;
	logic [8:0] fb2, synth;
	logic [5:0] prediv;
	logic [7:0][9:0] s_amp;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] ofs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
		8'h08, 8'h09, 8'h0C, 8'h1F, 8'h10};
	logic [7:0] msk [11] = '{8'hFF, 8'hFF, 8'hFF, 8'h81, 8'hEF, 8'hFF,
		8'h01, 8'hFF, 8'hBF, 8'h01, 8'h00};

	cod_host host (.CLOCK(clk), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .REG_RVALID(rvalid));

	cod_regs dut (.CLOCK(clk), .RSTN(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .FB_LOCK_WINDOW_PHASE(fb_ph),
		.SECOND_FB_POWER_DOWN(fb2_pd), .SECOND_FB_ENABLE(fb2_en),
		.VCXO_FEEDBACK_DIVIDER(vcxo), .SECOND_FEEDBACK_DIVIDER(fb2),
		.BYPASS_CONTROL(byp), .REF_LOCK_WINDOW_PHASE(ref_ph),
		.REFERENCE_DIVIDER(ref_div), .SYNTH_FEEDBACK_DIVIDER(synth),
		.DIVIDER_CONTROL_FLAG(flag), .SYNTH_PRE_DIVIDER(prediv),
		.OSCILLATOR_SELECT_BIT(osc), .SYSREF_POWERED(s_pw),
		.SYSREF_LVPECL(s_pecl), .SYSREF_TOGGLE(s_tog),
		.SYSREF_STATIC_LOW(s_low), .SYSREF_AMP_MV(s_amp));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk("rvalid", 16'h1, 16'(v));
		chk("rdata", 16'(e), 16'(d));
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(negedge clk);
		chk("vcxo", 16'hC00, 16'(vcxo));
		chk("fb2", 16'h060, 16'(fb2));
		chk("fb2_en", 16'h1, 16'(fb2_en));
		rchk(8'h00, 8'h0C);
		$display("reset test done");
		for (int i = 0; i < 11; i++) begin
			host.wr(ofs[i], 8'hFF);
			rchk(ofs[i], msk[i]);
		end
		chk("fb_ph", 16'h7, 16'(fb_ph));
		chk("fb2_pd", 16'h1, 16'(fb2_pd));
		chk("fb2_en", 16'h0, 16'(fb2_en));
		chk("fb2", 16'h1FF, 16'(fb2));
		chk("bypass", 16'h1, 16'(byp));
		chk("osc", 16'h1, 16'(osc));
		host.wr(8'h00, 8'hA5);
		host.wr(8'h04, 8'h6A);
		host.wr(8'h08, 8'hFE);
		host.wr(8'h0C, 8'h4A);
		@(negedge clk);
		chk("fb_ph", 16'h5, 16'(fb_ph));
		chk("fb2_en", 16'h1, 16'(fb2_en));
		chk("vcxo", 16'h5FF, 16'(vcxo));
		chk("ref_ph", 16'h3, 16'(ref_ph));
		chk("ref_div", 16'hAFF, 16'(ref_div));
		chk("synth", 16'h0FF, 16'(synth));
		chk("flag", 16'h0, 16'(flag));
		chk("prediv", 16'h0A, 16'(prediv));
		$display("divider test done");
		for (int p = 0; p < 2; p++) begin
			en_v = 8'h00;
			for (int i = 0; i < 8; i++) begin
				en_v[7 - i] = i[1];
				sv = {p[0], 2'h0, i[0], 2'(i), 2'h0};
				host.wr(OFS_SYSREF[i], sv);
				rchk(OFS_SYSREF[i], sv);
			end
			host.wr(OFS_SYSREF_EN, en_v);
			repeat (2) @(negedge clk);
			for (int i = 0; i < 8; i++) begin
				chk("powered", 16'(!p[0]), 16'(s_pw[i]));
				chk("lvpecl", 16'(i[0] & !p[0]), 16'(s_pecl[i]));
				chk("toggle", 16'(i[1] & !p[0]), 16'(s_tog[i]));
				chk("low", 16'(!i[1] & !p[0]), 16'(s_low[i]));
				chk("amp", p[0] ? 16'h0 : 16'(250 * (i % 4 + 1)),
					16'(s_amp[i]));
			end
		end
		$display("output test done");
		finish_test();
	end
endmodule // test_cod_regs
